// File: hw/uft_core.v
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "uft_defs.vh"

// What this block does
// - Separate four-byte receive and transmit FIFOs.
// - Receive interrupt when occupancy rises above threshold.
// - Transmit interrupt when occupancy falls below threshold.
// - Host sets both thresholds independently.
// - Two timers, baud generator or general timer.
// - Split rates use both timers, else one free.
// - Command loads count, then decrements per clock.
// - General-timer expiry raises a maskable interrupt.
// - Every received character checked against control set.
// - Control character match raises its own interrupt.
// - Host selects the control recognition mode.
// - Twenty sources grouped into six blocks.
// - Fixed hardware priority resolves pending blocks.
// - One combined interrupt output to host.
// - Report highest block, all blocks, and source.
// - Masking at block and source level.
// - Auto acknowledge on service, or manual command.
module uft_core (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Host register port
  input wire [`UFT_AW-1:0] reg_addr,
  input wire [`UFT_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`UFT_DW-1:0] reg_rdata,
  // Receive machine side
  input wire rx_char_valid,
  input wire [`UFT_DW-1:0] rx_char,
  input wire [3:0] rx_mach_event,
  // Transmit machine side
  output wire tx_char_valid,
  output wire [`UFT_DW-1:0] tx_char,
  input wire tx_char_take,
  input wire [1:0] tx_mach_event,
  // Modem and baud clocks
  input wire [6:0] modem_event,
  output wire tx_baud_tick,
  output wire rx_baud_tick,
  // Interrupt
  output wire irq
);

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  wire rd_rxd = reg_rd && (reg_addr == `UFT_OFF_RXD);
  wire wr_txd = reg_wr && (reg_addr == `UFT_OFF_TXD);
  wire wr_ack = reg_wr && (reg_addr == `UFT_OFF_ACK);
  wire wr_tcmd = reg_wr && (reg_addr == `UFT_OFF_TCMD);

  reg [`UFT_DW-1:0] fthr;
  reg [`UFT_DW-1:0] tcfg;
  reg [`UFT_DW-1:0] ccfg;
  reg [`UFT_DW-1:0] ucc0;
  reg [`UFT_DW-1:0] ucc1;
  reg [`UFT_DW-1:0] t0_lo;
  reg [`UFT_DW-1:0] t0_hi;
  reg [`UFT_DW-1:0] t1_lo;
  reg [`UFT_DW-1:0] t1_hi;
  reg [`UFT_NBLK-1:0] bmask;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fthr <= `UFT_RST_FTHR;
      tcfg <= `UFT_RST_BYTE;
      ccfg <= `UFT_RST_BYTE;
      ucc0 <= `UFT_RST_BYTE;
      ucc1 <= `UFT_RST_BYTE;
      t0_lo <= `UFT_RST_BYTE;
      t0_hi <= `UFT_RST_BYTE;
      t1_lo <= `UFT_RST_BYTE;
      t1_hi <= `UFT_RST_BYTE;
      bmask <= `UFT_RST_BMASK;
    end else if (reg_wr) begin
      case (reg_addr)
        `UFT_OFF_FTHR: fthr <= reg_wdata;
        `UFT_OFF_TCFG: tcfg <= reg_wdata;
        `UFT_OFF_CCFG: ccfg <= reg_wdata;
        `UFT_OFF_UCC0: ucc0 <= reg_wdata;
        `UFT_OFF_UCC1: ucc1 <= reg_wdata;
        `UFT_OFF_T0L: t0_lo <= reg_wdata;
        `UFT_OFF_T0H: t0_hi <= reg_wdata;
        `UFT_OFF_T1L: t1_lo <= reg_wdata;
        `UFT_OFF_T1H: t1_hi <= reg_wdata;
        `UFT_OFF_BMASK: bmask <= reg_wdata[`UFT_NBLK-1:0];
        default: bmask <= bmask;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------------
  reg [`UFT_PW-1:0] rx_wp;
  reg [`UFT_PW-1:0] rx_rp;
  reg [`UFT_CW-1:0] rx_cnt;
  wire [`UFT_DW-1:0] rx_head;
  wire rx_full = (rx_cnt == `UFT_FIFO_DEPTH);
  wire rx_push = rx_char_valid && !rx_full;
  wire rx_pop = rd_rxd && (rx_cnt != {`UFT_CW{1'b0}});
  wire [`UFT_PW-1:0] next_rx_rp = rx_rp + {1'b0, rx_pop};
  wire [`UFT_CW-1:0] next_rx_cnt = rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
    end else begin
      rx_wp <= rx_wp + {1'b0, rx_push};
      rx_rp <= next_rx_rp;
      rx_cnt <= next_rx_cnt;
    end
  end

  // Head of the queue always sits in the memory's output register.
  uft_fifo_mem u_rx_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(rx_push),
    .wr_addr(rx_wp),
    .wr_data(rx_char),
    .rd_addr(next_rx_rp),
    .rd_data(rx_head)
  );

  wire rx_thr_event = (next_rx_cnt > fthr[`UFT_FTHR_RX]) &&
                      (rx_cnt <= fthr[`UFT_FTHR_RX]) && rx_push;
  wire rx_ovf_event = rx_char_valid && rx_full;

  // --------------------------------------------------------------------
  // Transmit FIFO
  // --------------------------------------------------------------------
  reg [`UFT_PW-1:0] tx_wp;
  reg [`UFT_PW-1:0] tx_rp;
  reg [`UFT_CW-1:0] tx_cnt;
  wire tx_full = (tx_cnt == `UFT_FIFO_DEPTH);
  wire tx_push = wr_txd && !tx_full;
  wire tx_pop = tx_char_take && tx_char_valid;
  wire [`UFT_PW-1:0] next_tx_rp = tx_rp + {1'b0, tx_pop};
  wire [`UFT_CW-1:0] next_tx_cnt = tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop};

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
    end else begin
      tx_wp <= tx_wp + {1'b0, tx_push};
      tx_rp <= next_tx_rp;
      tx_cnt <= next_tx_cnt;
    end
  end

  uft_fifo_mem u_tx_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(tx_push),
    .wr_addr(tx_wp),
    .wr_data(reg_wdata),
    .rd_addr(next_tx_rp),
    .rd_data(tx_char)
  );

  assign tx_char_valid = (tx_cnt != 3'h0);

  wire tx_thr_event = (next_tx_cnt < fthr[`UFT_FTHR_TX]) &&
                      (tx_cnt >= fthr[`UFT_FTHR_TX]) && tx_pop;
  wire tx_ovf_event = wr_txd && tx_full;

  // --------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------
  wire [`UFT_TW-1:0] t0_count;
  wire [`UFT_TW-1:0] t1_count;
  wire t0_run;
  wire t1_run;
  wire t0_exp;
  wire t1_exp;

  uft_timer u_timer0 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(wr_tcmd && reg_wdata[`UFT_TCMD_LD0]),
    .load_value({t0_hi, t0_lo}),
    .baud_mode(tcfg[`UFT_TCFG_T0BAUD]),
    .count(t0_count),
    .running(t0_run),
    .expire(t0_exp)
  );

  uft_timer u_timer1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(wr_tcmd && reg_wdata[`UFT_TCMD_LD1]),
    .load_value({t1_hi, t1_lo}),
    .baud_mode(tcfg[`UFT_TCFG_T1BAUD]),
    .count(t1_count),
    .running(t1_run),
    .expire(t1_exp)
  );

  // Without split rates timer 1 stays free for general timing.
  wire t0_tick = t0_exp && tcfg[`UFT_TCFG_T0BAUD];
  wire t1_tick = t1_exp && tcfg[`UFT_TCFG_T1BAUD];
  assign tx_baud_tick = t0_tick;
  assign rx_baud_tick = tcfg[`UFT_TCFG_SPLIT] ? t1_tick : t0_tick;

  // Baud-mode expiries are not events; they would swamp the host.
  wire [1:0] tmr_event = {t1_exp && !tcfg[`UFT_TCFG_T1BAUD],
                          t0_exp && !tcfg[`UFT_TCFG_T0BAUD]};

  // --------------------------------------------------------------------
  // Control character recognition
  // --------------------------------------------------------------------
  reg cc_match;

  always @* begin
    cc_match = 1'b0;
    case (ccfg[`UFT_CCFG_MODE])
      `UFT_CC_ASCII: begin
        case (rx_char)
          8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h15,
          8'h17: cc_match = 1'b1;
          default: cc_match = 1'b0;
        endcase
      end
      `UFT_CC_EBCDIC: begin
        case (rx_char)
          8'h01, 8'h02, 8'h03, 8'h37, 8'h2D, 8'h2E, 8'h10, 8'h3D,
          8'h26: cc_match = 1'b1;
          default: cc_match = 1'b0;
        endcase
      end
      `UFT_CC_USER: cc_match = (rx_char == ucc0) || (rx_char == ucc1);
      default: cc_match = 1'b0;
    endcase
  end

  wire cc_event = rx_char_valid && cc_match;

  // --------------------------------------------------------------------
  // Interrupt manager
  // --------------------------------------------------------------------
  // Block order gives priority: timer, tx machine, rx machine,
  // rx FIFO, tx FIFO, modem.
  wire [47:0] src_event = {1'b0, modem_event,
                           6'h00, tx_ovf_event, tx_thr_event,
                           6'h00, rx_ovf_event, rx_thr_event,
                           3'h0, rx_mach_event, cc_event,
                           6'h00, tx_mach_event,
                           6'h00, tmr_event};
  wire [47:0] src_valid = `UFT_SRC_VALID;
  wire [47:0] stat_flat;
  wire [47:0] smask_flat;
  wire [`UFT_NBLK-1:0] blk_pend;
  reg [2:0] top_blk;
  wire auto_ack = ccfg[`UFT_CCFG_AUTO];

  genvar b;
  generate
    for (b = 0; b < `UFT_NBLK; b = b + 1) begin : g_blk
      reg [7:0] stat;
      reg [7:0] smask;
      reg [7:0] clr;
      wire [31:0] sa = `UFT_OFF_SSTAT + b;
      wire [31:0] ma = `UFT_OFF_SMASK + b;

      always @* begin
        clr = 8'h00;
        if (reg_wr && (reg_addr == sa)) begin
          clr = reg_wdata;
        end
        if (auto_ack && reg_rd && (reg_addr == sa)) begin
          clr = clr | stat;
        end
        if (wr_ack && (top_blk == b)) begin
          clr = 8'hFF;
        end
      end

      // A new event in the clearing cycle survives the clear.
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stat <= 8'h00;
          smask <= `UFT_RST_SMASK;
        end else begin
          stat <= ((stat & ~clr) | src_event[b*8 +: 8]) &
                  src_valid[b*8 +: 8];
          if (reg_wr && (reg_addr == ma)) begin
            smask <= reg_wdata;
          end
        end
      end

      assign stat_flat[b*8 +: 8] = stat;
      assign smask_flat[b*8 +: 8] = smask;
      assign blk_pend[b] = |(stat & smask) && bmask[b];
    end
  endgenerate

  integer i;

  // The lowest index wins, so the timer block comes first.
  always @* begin
    top_blk = `UFT_BLK_NONE;
    for (i = `UFT_NBLK - 1; i >= 0; i = i - 1) begin
      if (blk_pend[i]) begin
        top_blk = i[2:0];
      end
    end
  end

  assign irq = |blk_pend;

  // --------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------------
  wire [4:0] s_idx = reg_addr - `UFT_OFF_SSTAT;
  wire [4:0] m_idx = reg_addr - `UFT_OFF_SMASK;
  reg [`UFT_DW-1:0] rd_val;

  always @* begin
    rd_val = 8'h00;
    case (reg_addr)
      `UFT_OFF_RXD: rd_val = rx_head;
      `UFT_OFF_FTHR: rd_val = fthr;
      `UFT_OFF_FOCC: rd_val = {1'b0, tx_cnt, 1'b0, rx_cnt};
      `UFT_OFF_TCFG: rd_val = tcfg;
      `UFT_OFF_T0L: rd_val = t0_count[7:0];
      `UFT_OFF_T0H: rd_val = t0_count[15:8];
      `UFT_OFF_T1L: rd_val = t1_count[7:0];
      `UFT_OFF_T1H: rd_val = t1_count[15:8];
      `UFT_OFF_TSTAT: rd_val = {6'h00, t1_run, t0_run};
      `UFT_OFF_CCFG: rd_val = ccfg;
      `UFT_OFF_UCC0: rd_val = ucc0;
      `UFT_OFF_UCC1: rd_val = ucc1;
      `UFT_OFF_HPB: rd_val = {5'h00, top_blk};
      `UFT_OFF_APB: rd_val = {2'h0, blk_pend};
      `UFT_OFF_BMASK: rd_val = {2'h0, bmask};
      default: begin
        if (s_idx < `UFT_NBLK) begin
          rd_val = stat_flat[s_idx[2:0]*8 +: 8];
        end else if (m_idx < `UFT_NBLK) begin
          rd_val = smask_flat[m_idx[2:0]*8 +: 8];
        end
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `UFT_RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rd_val : `UFT_RST_BYTE;
    end
  end

endmodule // uft_core

// File: hw/uft_defs.vh
`ifndef UFT_DEFS_VH
`define UFT_DEFS_VH

// ----------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------
`define UFT_DW 8
`define UFT_AW 5
`define UFT_PW 2
`define UFT_CW 3
`define UFT_FIFO_DEPTH 3'h4
`define UFT_TW 16
`define UFT_NBLK 6

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UFT_OFF_RXD 5'h00
`define UFT_OFF_TXD 5'h01
`define UFT_OFF_FTHR 5'h02
`define UFT_OFF_FOCC 5'h03
`define UFT_OFF_TCFG 5'h04
`define UFT_OFF_TCMD 5'h05
`define UFT_OFF_T0L 5'h06
`define UFT_OFF_T0H 5'h07
`define UFT_OFF_T1L 5'h08
`define UFT_OFF_T1H 5'h09
`define UFT_OFF_TSTAT 5'h0A
`define UFT_OFF_CCFG 5'h0B
`define UFT_OFF_UCC0 5'h0C
`define UFT_OFF_UCC1 5'h0D
`define UFT_OFF_HPB 5'h0E
`define UFT_OFF_APB 5'h0F
`define UFT_OFF_BMASK 5'h10
`define UFT_OFF_ACK 5'h11
`define UFT_OFF_SSTAT 5'h12
`define UFT_OFF_SMASK 5'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UFT_FTHR_RX 2:0
`define UFT_FTHR_TX 6:4
`define UFT_TCFG_T0BAUD 0
`define UFT_TCFG_T1BAUD 1
`define UFT_TCFG_SPLIT 2
`define UFT_TCMD_LD0 0
`define UFT_TCMD_LD1 1
`define UFT_CCFG_MODE 1:0
`define UFT_CCFG_AUTO 2

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define UFT_CC_OFF 2'h0
`define UFT_CC_ASCII 2'h1
`define UFT_CC_EBCDIC 2'h2
`define UFT_CC_USER 2'h3
`define UFT_BLK_NONE 3'h7
`define UFT_RST_FTHR 8'h00
`define UFT_RST_SMASK 8'hFF
`define UFT_RST_BMASK 6'h00
`define UFT_RST_BYTE 8'h00
`define UFT_SRC_VALID 48'h7F_03_03_1F_03_03

`endif

// File: hw/uft_fifo_mem.v
`timescale 1ns/100ps
`include "uft_defs.vh"

module uft_fifo_mem (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Write port
  input wire wr_en,
  input wire [`UFT_PW-1:0] wr_addr,
  input wire [`UFT_DW-1:0] wr_data,
  // Read port
  input wire [`UFT_PW-1:0] rd_addr,
  output reg [`UFT_DW-1:0] rd_data
);

  reg [`UFT_DW-1:0] mem [0:3];

  // Written data is forwarded so a head slot filled this cycle is seen.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `UFT_RST_BYTE;
    end else if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule // uft_fifo_mem

// File: hw/uft_timer.v
`timescale 1ns/100ps
`include "uft_defs.vh"

module uft_timer (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [`UFT_TW-1:0] load_value,
  input wire baud_mode,
  // State
  output reg [`UFT_TW-1:0] count,
  output reg running,
  output reg expire
);

  reg [`UFT_TW-1:0] reload;

  // A general timer stops at expiry; a baud generator reloads and runs on.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {`UFT_TW{1'b0}};
      reload <= {`UFT_TW{1'b0}};
      running <= 1'b0;
      expire <= 1'b0;
    end else if (load) begin
      count <= load_value;
      reload <= load_value;
      running <= 1'b1;
      expire <= 1'b0;
    end else if (running && (count <= {{(`UFT_TW-1){1'b0}}, 1'b1})) begin
      expire <= 1'b1;
      count <= baud_mode ? reload : {`UFT_TW{1'b0}};
      running <= baud_mode;
    end else if (running) begin
      count <= count - {{(`UFT_TW-1){1'b0}}, 1'b1};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
    end
  end

endmodule // uft_timer

// File: sim/uft_sva.sv
`timescale 1ns/100ps
`include "uft_defs.vh"

module uft_sva (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Register port
  input wire [`UFT_AW-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`UFT_DW-1:0] reg_rdata,
  // Transmit side and interrupt
  input wire tx_char_valid,
  input wire [`UFT_DW-1:0] tx_char,
  input wire tx_char_take,
  input wire irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------------
  // Status reporting
  // --------------------------------------------------------------------
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_hpb_none: assert property (
    reg_rd && reg_addr == `UFT_OFF_HPB |=> (reg_rdata == 8'h07) == !$past(irq))
    else $error("highest block report disagrees with irq");
  a_hpb_range: assert property (
    reg_rd && reg_addr == `UFT_OFF_HPB |=> reg_rdata <= 8'h05 ||
      reg_rdata == 8'h07)
    else $error("highest block code out of range");
  a_apb_irq: assert property (
    reg_rd && reg_addr == `UFT_OFF_APB |=> (reg_rdata != 8'h00) == $past(irq))
    else $error("pending block report disagrees with irq");

  // --------------------------------------------------------------------
  // Transmit FIFO
  // --------------------------------------------------------------------
  a_txv_rise: assert property (
    $rose(tx_char_valid) |-> $past(reg_wr && reg_addr == `UFT_OFF_TXD))
    else $error("transmit data appeared without a push");
  a_tx_hold: assert property (
    tx_char_valid && !tx_char_take |=> tx_char_valid && $stable(tx_char))
    else $error("transmit head changed without a take");
  a_focc_range: assert property (
    reg_rd && reg_addr == `UFT_OFF_FOCC |=> reg_rdata[2:0] <= 3'h4 &&
      reg_rdata[6:4] <= 3'h4 && !reg_rdata[3] && !reg_rdata[7])
    else $error("occupancy beyond four bytes");
  a_txv_focc: assert property (
    reg_rd && reg_addr == `UFT_OFF_FOCC |=>
      (reg_rdata[6:4] != 3'h0) == $past(tx_char_valid))
    else $error("transmit valid disagrees with occupancy");
endmodule // uft_sva

// File: sim/uft_host.sv
`timescale 1ns/100ps
`include "uft_defs.vh"

module uft_host (
  // Clock
  input wire sys_clk,
  // Register port
  output logic [`UFT_AW-1:0] reg_addr,
  output logic [`UFT_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [`UFT_DW-1:0] reg_rdata
);
  initial begin
    reg_addr = 5'h1F;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines are inverted so that no stale value looks valid.
  task wr(input logic [`UFT_AW-1:0] a, input logic [`UFT_DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task rd(input logic [`UFT_AW-1:0] a, output logic [`UFT_DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // The answer stands only in the cycle after the strobe.
    #1;
    d = reg_rdata;
  endtask
endmodule // uft_host

// File: sim/test_uft_core.sv
`timescale 1ns/100ps
`include "uft_defs.vh"

`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("MISMATCH at %0t got %h expected %h", $time, a, e); \
  end \
end

module test_uft_core;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_char_valid = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic [3:0] rx_mach_event = 4'h0;
  logic tx_char_take = 1'b0;
  logic [1:0] tx_mach_event = 2'h0;
  logic [6:0] modem_event = 7'h00;
  wire [4:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire [7:0] tx_char;
  wire reg_wr;
  wire reg_rd;
  wire tx_char_valid;
  wire tx_baud_tick;
  wire rx_baud_tick;
  wire irq;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  integer nt;
  integer nr;
  logic [7:0] k;
  logic [31:0] hs = 32'h05020100;

  initial forever #20 sys_clk = ~sys_clk;

  uft_core i_uft_core (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_mach_event(rx_mach_event), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_take(tx_char_take),
    .tx_mach_event(tx_mach_event), .modem_event(modem_event),
    .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick), .irq(irq));

  uft_host i_uft_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  task w(input logic [4:0] a, input logic [7:0] d);
    i_uft_host.wr(a, d);
  endtask

  task rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_uft_host.rd(a, d);
    `CHK(d, e)
  endtask

  task ci(input logic e);
    #1;
    `CHK(irq, e)
  endtask

  task rx(input logic [7:0] c);
    @(posedge sys_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask

  task ev(input logic [3:0] r, input logic [1:0] t, input logic [6:0] m);
    @(posedge sys_clk);
    rx_mach_event <= r;
    tx_mach_event <= t;
    modem_event <= m;
    @(posedge sys_clk);
    rx_mach_event <= 4'h0;
    tx_mach_event <= 2'h0;
    modem_event <= 7'h00;
  endtask

  // The head register follows a pop at the same edge; the second edge is only margin.
  task take(input logic [7:0] e);
    @(posedge sys_clk);
    @(posedge sys_clk);
    `CHK(tx_char_valid, 1'b1)
    `CHK(tx_char, e)
    tx_char_take <= 1'b1;
    @(posedge sys_clk);
    tx_char_take <= 1'b0;
  endtask

  task cc(input logic [1:0] m, input logic [7:0] c, input logic [7:0] e);
    w(5'h0B, {6'h01, m});
    rx(c);
    rc(5'h14, e);
  endtask

  task cnt;
    nt = 0;
    nr = 0;
    repeat (12) @(posedge sys_clk);
    repeat (60) begin
      @(negedge sys_clk);
      nt += tx_baud_tick;
      nr += rx_baud_tick;
    end
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(5'h02, 8'h00);
    rc(5'h03, 8'h00);
    rc(5'h04, 8'h00);
    rc(5'h0B, 8'h00);
    rc(5'h0E, 8'h07);
    rc(5'h0F, 8'h00);
    rc(5'h10, 8'h00);
    rc(5'h18, 8'hFF);
    rc(5'h1E, 8'h00);
    done("reset values");
    w(5'h02, 8'h31);
    rc(5'h02, 8'h31);
    w(5'h10, 8'h18);
    for (k = 8'h00; k < 8'h05; k++) rx(8'h41 + k);
    rc(5'h03, 8'h04);
    rc(5'h15, 8'h03);
    ci(1'b1);
    rc(5'h0E, 8'h03);
    for (k = 8'h00; k < 8'h04; k++) rc(5'h00, 8'h41 + k);
    w(5'h15, 8'h03);
    ci(1'b0);
    done("rx fifo");
    for (k = 8'h00; k < 8'h05; k++) w(5'h01, 8'h50 + k);
    rc(5'h03, 8'h40);
    for (k = 8'h00; k < 8'h04; k++) take(8'h50 + k);
    #1;
    `CHK(tx_char_valid, 1'b0)
    rc(5'h16, 8'h03);
    rc(5'h0E, 8'h04);
    w(5'h16, 8'h03);
    done("tx fifo");
    w(5'h06, 8'h05);
    w(5'h07, 8'h00);
    w(5'h05, 8'h01);
    rc(5'h0A, 8'h01);
    repeat (8) @(posedge sys_clk);
    rc(5'h0A, 8'h00);
    rc(5'h06, 8'h00);
    rc(5'h12, 8'h01);
    ci(1'b0);
    w(5'h10, 8'h3F);
    ci(1'b1);
    ev(4'h1, 2'h1, 7'h01);
    rc(5'h0F, 8'h27);
    for (k = 8'h00; k < 8'h04; k++) begin
      rc(5'h0E, hs[8*k +: 8]);
      w(5'h11, 8'h00);
    end
    rc(5'h0E, 8'h07);
    ci(1'b0);
    done("timer and priority");
    w(5'h1D, 8'hFE);
    ev(4'h0, 2'h0, 7'h01);
    ci(1'b0);
    rc(5'h17, 8'h01);
    ev(4'h0, 2'h0, 7'h02);
    ci(1'b1);
    w(5'h17, 8'h03);
    ci(1'b0);
    w(5'h0C, 8'h5A);
    w(5'h0B, 8'h04);
    ev(4'h0, 2'h2, 7'h00);
    rc(5'h13, 8'h02);
    rc(5'h13, 8'h00);
    cc(2'h1, 8'h03, 8'h01);
    cc(2'h2, 8'h37, 8'h01);
    cc(2'h3, 8'h5A, 8'h01);
    cc(2'h0, 8'h03, 8'h00);
    cc(2'h1, 8'h41, 8'h00);
    done("control chars");
    w(5'h04, 8'h07);
    w(5'h06, 8'h04);
    w(5'h08, 8'h06);
    w(5'h05, 8'h03);
    cnt;
    `CHK(nt, 15)
    `CHK(nr, 10)
    rc(5'h12, 8'h00);
    w(5'h04, 8'h03);
    cnt;
    `CHK(nr, 15)
    done("baud");
    final_report;
  end
endmodule // test_uft_core

bind uft_core uft_sva i_uft_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_char_valid(tx_char_valid),
  .tx_char(tx_char), .tx_char_take(tx_char_take), .irq(irq));
